// File: design/act_bc_divider.sv
/*
  act_bc_divider: basic-clock tick generator, one pulse every ratio
  system clocks. assumes ratio is at least one and a restart pulse
  realigns the phase so a conversion starts on a clean boundary.
*/
`timescale 1ns/1ps
module act_bc_divider (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // control
  input  wire logic [7:0] ratio,
  input  wire logic       restart,
  // tick out
  output logic            tick
);

  logic [7:0] count;  // system clocks into the current basic clock
  logic [7:0] last;   // terminal count for the current ratio

  // a zero ratio is treated as one so the tick never stops
  assign last = (ratio == 8'h00) ? 8'h00 : ratio - 8'h01;
  assign tick = (count == last);

  // phase counter; a shrinking ratio wraps at once instead of
  // running through 256 counts
  always_ff @(posedge core_clk) begin
    if (rst || restart) begin
      count <= 8'h00;
    end else if (count >= last) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

endmodule : act_bc_divider

// File: design/act_pkg.sv
/*
  act_pkg: shared constants for the converter timing block: register
  offsets, field positions, reset values, phase lengths and states.
  assumes: 32-bit AXI4-Lite register access, one aligned word per register.
*/
package act_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;  // adc_control
  localparam logic [7:0] ADDR_STATUS  = 8'h04;  // busy / calibration state
  localparam logic [7:0] ADDR_RESULT  = 8'h08;  // last conversion result
  localparam logic [7:0] ADDR_ALT_DIV = 8'h0C;  // improved clock divisor

  // adc_control field positions
  localparam int CTRL_DIV_LSB     = 14;  // conv_clock_divider_select
  localparam int CTRL_SMP_LSB     = 12;  // sample_period_select
  localparam int CTRL_ALT_BIT     = 3;   // improved clock mode
  localparam int CTRL_RES8_BIT    = 2;   // 8-bit result width
  localparam int CTRL_POSTCAL_BIT = 1;   // post-calibration enable
  localparam int CTRL_START_BIT   = 0;   // write one to start

  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CAL_BIT  = 1;
  localparam int STAT_NEW_BIT  = 2;

  // values after reset
  localparam logic [15:0] CONTROL_RESET = 16'h0002;  // post-cal on
  localparam logic [7:0]  ALT_DIV_RESET = 8'h03;     // divide by 4

  // compatibility divider ratios, system clocks per basic clock
  localparam logic [7:0] DIV_RATIO_00 = 8'h04;
  localparam logic [7:0] DIV_RATIO_01 = 8'h02;
  localparam logic [7:0] DIV_RATIO_10 = 8'h10;
  localparam logic [7:0] DIV_RATIO_11 = 8'h08;

  // sample period lengths in basic clocks
  localparam logic [6:0] SAMPLE_BC_00 = 7'h08;  // 8
  localparam logic [6:0] SAMPLE_BC_01 = 7'h10;  // 16
  localparam logic [6:0] SAMPLE_BC_10 = 7'h20;  // 32
  localparam logic [6:0] SAMPLE_BC_11 = 7'h40;  // 64

  // result determination lengths in basic clocks
  localparam logic [6:0] CONV_BC_10_PCAL = 7'h34;  // 52
  localparam logic [6:0] CONV_BC_10      = 7'h28;  // 40
  localparam logic [6:0] CONV_BC_8_PCAL  = 7'h2C;  // 44
  localparam logic [6:0] CONV_BC_8       = 7'h20;  // 32

  // system-clock tail that holds the result register load
  localparam logic [2:0] SYS_TAIL_CYCLES = 3'h6;

  // reset calibration bounds in basic clocks
  localparam int CAL_MIN_BC = 484;
  localparam int CAL_MAX_BC = 11696;

  // result codes for out-of-range inputs
  localparam logic [9:0] RESULT_ZERO = 10'h000;
  localparam logic [9:0] RESULT_FULL = 10'h3FF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SAMPLE  = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_FINISH  = 4'b1000
  } act_state_type;

endpackage : act_pkg

// File: design/act_timing.sv
/*
  act_timing: conversion timing and sequencing for the successive
  approximation converter, with its AXI4-Lite register slave.
  assumes: core_clk is the system clock, equal in rate to the cpu clock;
  the analog front end holds code and range flags steady while the
  finish phase runs, and raises cal_settled when reference noise allows.
*/
`timescale 1ns/1ps
// Operation
// - divider select gives sys/4, /2, /16, /8
// - sample select gives 8/16/32/64 basic clocks
// - 10-bit: sample + 52 or 40 + 6 sys
// - 8-bit: sample + 44 or 32 + 6 sys
// - result register loaded inside sys tail
// - reset calibration lasts 484 to 11696 basic clocks
// - conversions during calibration run and extend it
// - under ground gives 000, over ref 3FF
// - compatibility encodings plus selectable improved divider
// - system clock runs at cpu clock rate
module act_timing #(
  parameter int CAL_MIN = act_pkg::CAL_MIN_BC,  // least calibration length
  parameter int CAL_MAX = act_pkg::CAL_MAX_BC   // longest calibration length
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog front end control
  output logic             fe_sample,
  output logic             fe_convert,
  output logic             fe_calibrate,
  // analog front end answers
  input  wire logic [9:0]  fe_code,
  input  wire logic        fe_below_ground,
  input  wire logic        fe_above_ref,
  input  wire logic        fe_cal_settled,
  // user-side status
  output logic             busy,
  output logic [9:0]       result_data,
  output logic             result_load
);

  // registers
  logic [15:0] adc_control;      // divider, sample, mode bits
  logic [7:0]  alt_div;          // improved divisor minus one
  logic        result_new;       // sticky: result loaded, not yet read

  // write channel holding
  logic        aw_held;          // address taken, waiting for data
  logic        w_held;           // data taken, waiting for address
  logic [7:0]  aw_addr;          // held write address
  logic [31:0] w_data;           // held write data
  logic [3:0]  w_strb;           // held byte enables
  logic        wr_fire;          // both halves present this cycle
  logic        start_req;        // start bit written this cycle

  // read channel
  logic        rd_fire;

  // sequencer
  act_pkg::act_state_type state;       // conversion phase
  act_pkg::act_state_type next_state;  // phase for next edge
  logic [6:0]  bc_count;               // basic clocks into phase
  logic [2:0]  sys_count;              // system clocks into tail
  logic [6:0]  sample_len;             // chosen sample length
  logic [6:0]  conv_len;               // chosen determination length
  logic [7:0]  ratio;                  // system clocks per basic clock
  logic        bc_tick;                // one basic clock elapsed
  logic        start_go;               // conversion accepted

  // calibration
  logic        cal_active;             // reset calibration running
  logic [13:0] cal_count;              // basic clocks spent calibrating

  // write side: an address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid)
                   && !s_axi_bvalid;

  // hold each half until the other shows up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      // capture whichever half arrives alone
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // combined view of the write being committed
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb;

  // write response one cycle after commit, held until bready
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= act_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // unmapped offsets answer with an error, status is read-only
      case (wr_addr)
        act_pkg::ADDR_CONTROL,
        act_pkg::ADDR_ALT_DIV,
        act_pkg::ADDR_STATUS,
        act_pkg::ADDR_RESULT: s_axi_bresp <= act_pkg::RESP_OKAY;
        default:              s_axi_bresp <= act_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register; the start bit never stores, it only pulses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      adc_control <= act_pkg::CONTROL_RESET;
    end else if (wr_fire && wr_addr == act_pkg::ADDR_CONTROL) begin
      if (wr_strb[0]) begin
        adc_control[7:0] <= wr_data[7:0] & 8'hFE;
      end
      if (wr_strb[1]) begin
        adc_control[15:8] <= wr_data[15:8];
      end
    end
  end

  // improved-mode divisor register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alt_div <= act_pkg::ALT_DIV_RESET;
    end else if (wr_fire && wr_addr == act_pkg::ADDR_ALT_DIV
                 && wr_strb[0]) begin
      alt_div <= wr_data[7:0];
    end
  end

  assign start_req = wr_fire && wr_addr == act_pkg::ADDR_CONTROL
                     && wr_strb[0] && wr_data[act_pkg::CTRL_START_BIT];
  // a start while busy is dropped; the running conversion wins
  assign start_go = start_req && (state == act_pkg::ST_IDLE);

  // read side: one read at a time, answered the cycle after arvalid
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // read data and response
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= act_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= act_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      case (s_axi_araddr)
        act_pkg::ADDR_CONTROL: s_axi_rdata[15:0] <= adc_control;
        act_pkg::ADDR_ALT_DIV: s_axi_rdata[7:0]  <= alt_div;
        act_pkg::ADDR_STATUS: begin
          s_axi_rdata[act_pkg::STAT_BUSY_BIT] <= busy;
          s_axi_rdata[act_pkg::STAT_CAL_BIT]  <= cal_active;
          s_axi_rdata[act_pkg::STAT_NEW_BIT]  <= result_new;
        end
        act_pkg::ADDR_RESULT:  s_axi_rdata[9:0] <= result_data;
        default:               s_axi_rresp <= act_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // basic clock ratio: table in compatibility mode, else divisor + 1, held at 255 for divisor FF
  always_comb begin
    ratio = act_pkg::DIV_RATIO_00;
    if (adc_control[act_pkg::CTRL_ALT_BIT]) begin
      ratio = (alt_div == 8'hFF) ? 8'hFF : alt_div + 8'h01;
    end else begin
      case (adc_control[act_pkg::CTRL_DIV_LSB +: 2])
        2'b00:   ratio = act_pkg::DIV_RATIO_00;
        2'b01:   ratio = act_pkg::DIV_RATIO_01;
        2'b10:   ratio = act_pkg::DIV_RATIO_10;
        2'b11:   ratio = act_pkg::DIV_RATIO_11;
        default: ratio = act_pkg::DIV_RATIO_00;
      endcase
    end
  end

  // phase lengths from the mode bits
  always_comb begin
    case (adc_control[act_pkg::CTRL_SMP_LSB +: 2])
      2'b00:   sample_len = act_pkg::SAMPLE_BC_00;
      2'b01:   sample_len = act_pkg::SAMPLE_BC_01;
      2'b10:   sample_len = act_pkg::SAMPLE_BC_10;
      2'b11:   sample_len = act_pkg::SAMPLE_BC_11;
      default: sample_len = act_pkg::SAMPLE_BC_00;
    endcase
    case ({adc_control[act_pkg::CTRL_RES8_BIT],
           adc_control[act_pkg::CTRL_POSTCAL_BIT]})
      2'b01:   conv_len = act_pkg::CONV_BC_10_PCAL;
      2'b00:   conv_len = act_pkg::CONV_BC_10;
      2'b11:   conv_len = act_pkg::CONV_BC_8_PCAL;
      2'b10:   conv_len = act_pkg::CONV_BC_8;
      default: conv_len = act_pkg::CONV_BC_10;
    endcase
  end

  // one clock, system equals cpu rate
  act_bc_divider u_divider (
    .core_clk (core_clk),
    .rst      (rst),
    .ratio    (ratio),
    .restart  (start_go),
    .tick     (bc_tick)
  );

  // sequencer next phase; the tail is counted in system clocks
  always_comb begin
    next_state = state;
    case (state)
      act_pkg::ST_IDLE: begin
        if (start_go) begin
          next_state = act_pkg::ST_SAMPLE;
        end
      end
      act_pkg::ST_SAMPLE: begin
        if (bc_tick && bc_count == sample_len - 7'h01) begin
          next_state = act_pkg::ST_CONVERT;
        end
      end
      act_pkg::ST_CONVERT: begin
        if (bc_tick && bc_count == conv_len - 7'h01) begin
          next_state = act_pkg::ST_FINISH;
        end
      end
      act_pkg::ST_FINISH: begin
        if (sys_count == act_pkg::SYS_TAIL_CYCLES - 3'h1) begin
          next_state = act_pkg::ST_IDLE;
        end
      end
      default: next_state = act_pkg::ST_IDLE;
    endcase
  end

  // phase register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= act_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // basic clock counter, cleared at each phase change
  always_ff @(posedge core_clk) begin
    if (rst || next_state != state) begin
      bc_count <= 7'h00;
    end else if (bc_tick) begin
      bc_count <= bc_count + 7'h01;
    end
  end

  // system clock counter for the load tail
  always_ff @(posedge core_clk) begin
    if (rst || state != act_pkg::ST_FINISH) begin
      sys_count <= 3'h0;
    end else begin
      sys_count <= sys_count + 3'h1;
    end
  end

  // result load on the last tail cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_data <= act_pkg::RESULT_ZERO;
      result_load <= 1'b0;
    end else begin
      result_load <= 1'b0;
      if (state == act_pkg::ST_FINISH
          && sys_count == act_pkg::SYS_TAIL_CYCLES - 3'h1) begin
        result_load <= 1'b1;
        if (fe_below_ground) begin
          result_data <= act_pkg::RESULT_ZERO;
        end else if (fe_above_ref) begin
          result_data <= act_pkg::RESULT_FULL;
        end else if (adc_control[act_pkg::CTRL_RES8_BIT]) begin
          // 8-bit results sit in the top bits
          result_data <= {fe_code[9:2], 2'b00};
        end else begin
          result_data <= fe_code;
        end
      end
    end
  end

  // busy flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (start_go) begin
      busy <= 1'b1;
    end else if (state == act_pkg::ST_FINISH
                 && next_state == act_pkg::ST_IDLE) begin
      busy <= 1'b0;
    end
  end

  // sticky new-result flag: a load in the same cycle as the read wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_new <= 1'b0;
    end else if (state == act_pkg::ST_FINISH
                 && next_state == act_pkg::ST_IDLE) begin
      result_new <= 1'b1;
    end else if (rd_fire && s_axi_araddr == act_pkg::ADDR_RESULT) begin
      result_new <= 1'b0;
    end
  end

  // reset calibration; counting pauses while a conversion runs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_active <= 1'b1;
      cal_count  <= 14'h0000;
    end else if (cal_active && bc_tick && !busy) begin
      cal_count <= cal_count + 14'h0001;
      if (cal_count == 14'(CAL_MAX - 1)
          || (cal_count >= 14'(CAL_MIN - 1) && fe_cal_settled)) begin
        cal_active <= 1'b0;
      end
    end
  end

  // front end control levels
  assign fe_sample    = (state == act_pkg::ST_SAMPLE);
  assign fe_convert   = (state == act_pkg::ST_CONVERT);
  assign fe_calibrate = cal_active;

  // software keeps basic clock in range; the divider does not
  // police it, so an out-of-range ratio simply runs as programmed

endmodule : act_timing

// File: sim/act_fe_model.sv
/*
  act_fe_model: behavioural analog front end beside the timing block.
  assumes: bench sets the input level, code and settling delay.
*/
`timescale 1ns/1ps
module act_fe_model (
  // clock
  input wire logic        core_clk,
  // converter control
  input wire logic        fe_sample,
  input wire logic        fe_convert,
  input wire logic        fe_calibrate,
  // analog stand-in from the bench
  input wire logic [1:0]  ain_mode,
  input wire logic [9:0]  ain_code,
  input wire logic [15:0] settle_after,
  // answers
  output logic [9:0]      fe_code,
  output logic            fe_below_ground,
  output logic            fe_above_ref,
  output logic            fe_cal_settled
);
  logic [15:0] cal_n;  // cycles spent calibrating

  initial begin
    fe_code = 10'h155;
    fe_below_ground = 1'h0;
    fe_above_ref = 1'h0;
    fe_cal_settled = 1'h0;
    cal_n = 16'h0000;
  end

  always @(posedge core_clk) begin
    if (fe_sample || fe_convert) begin
      // unresolved lines toggle so no stale value passes
      fe_code <= ~fe_code;
      fe_below_ground <= ~fe_below_ground;
      fe_above_ref <= ~fe_above_ref;
    end else begin
      fe_code <= ain_code;
      fe_below_ground <= ain_mode == 2'h1;
      fe_above_ref <= ain_mode == 2'h2;
    end
    // settling set by reference noise; an unknown level counts as off
    if (fe_calibrate) begin
      cal_n <= cal_n + 16'h0001;
    end else begin
      cal_n <= 16'h0000;
    end
    fe_cal_settled <= fe_calibrate && cal_n >= settle_after;
  end
endmodule : act_fe_model

// File: sim/act_timing_properties.sv
/*
  act_timing_properties: port-level checks of the converter timing block.
  assumes: single core_clk domain, rst synchronous active high.
*/
`timescale 1ns/1ps
module act_timing_properties #(
  parameter int CAL_MIN = act_pkg::CAL_MIN_BC,  // least calibration length
  parameter int CAL_MAX = act_pkg::CAL_MAX_BC   // longest calibration length
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // front end and status
  input wire logic        fe_sample,
  input wire logic        fe_convert,
  input wire logic        fe_calibrate,
  input wire logic        busy,
  input wire logic [9:0]  result_data,
  input wire logic        result_load
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // write commit and start request
  wire logic go = s_axi_awvalid && s_axi_awready
                  && s_axi_wvalid && s_axi_wready;
  wire logic start = go && s_axi_awaddr == act_pkg::ADDR_CONTROL
                     && s_axi_wstrb[0] && s_axi_wdata[0] && !busy;

  start_busy_a: assert property (start |=> busy && fe_sample)
    else $error("start did not raise busy and sampling");
  sample_min_a: assert property ($rose(fe_sample) |-> fe_sample[*8])
    else $error("sample phase shorter than eight cycles");
  phase_order_a: assert property ($fell(fe_sample) && busy |-> fe_convert)
    else $error("result phase did not follow sampling");
  tail_len_a: assert property ($fell(fe_convert) |->
    (busy && !result_load)[*6] ##1 (result_load && !busy))
    else $error("result load not six cycles after conversion");
  load_pulse_a: assert property (result_load |=> !result_load)
    else $error("result load longer than one cycle");
  no_overlap_a: assert property (!(fe_sample && fe_convert))
    else $error("sample and convert both high");
  result_hold_a: assert property (!result_load |-> $stable(result_data))
    else $error("result changed without load");
  busy_end_a: assert property ($fell(busy) |-> result_load)
    else $error("busy dropped without result load");
  wr_answer_a: assert property (go |=> s_axi_bvalid)
    else $error("write response late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > 8'h0C |=> s_axi_rresp == act_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");

  // main scenarios seen
  load_seen_c: cover property (result_load);
  cal_end_c: cover property ($fell(fe_calibrate));
  conv_in_cal_c: cover property (fe_calibrate && busy);
endmodule : act_timing_properties

bind act_timing act_timing_properties #(
  .CAL_MIN(CAL_MIN), .CAL_MAX(CAL_MAX)) u_props (.*);

// File: sim/adc_conversion_timing_bench.sv
/*
  adc_conversion_timing_bench: register-level tests of the timing block.
  assumes: design runs with CAL_MIN 4 and CAL_MAX 20 to keep runs short.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("[ERR] %0t got %0h want %0h", $time, (g), (e)); end end
module adc_conversion_timing_bench;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, ain_mode;
  logic fe_sample, fe_convert, fe_calibrate, fe_below_ground;
  logic fe_above_ref, fe_cal_settled, busy, result_load;
  logic [9:0] fe_code, result_data, ain_code;
  logic [15:0] settle_after, ctl;
  int miscompares, check_count, cycles, i, k;
  realtime t0, t_commit, t_cal;
  int rt[4] = '{4, 2, 16, 8};     // divider ratios
  int st[4] = '{8, 16, 32, 64};   // sample lengths
  int ct[4] = '{52, 40, 44, 32};  // result lengths

  act_timing #(.CAL_MIN(4), .CAL_MAX(20)) dut (.*);
  act_fe_model fe (.*);

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  // calibration end time
  always @(negedge fe_calibrate) t_cal = $realtime;

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    logic ga, gw;
    ga = 1'h0;
    gw = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ga && gw)) begin
      @(posedge core_clk);
      if (s_axi_awready && !ga) begin
        ga = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !gw) begin
        gw = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    t_commit = $realtime;
    do @(posedge core_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    // answer left waiting one cycle so its hold is exercised
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h1;
    @(posedge core_clk);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  // start, then time the conversion to its result load
  task automatic conv(input logic [15:0] c, input int n,
                      input logic [9:0] e);
    logic [1:0] rs;
    int j;
    wr(act_pkg::ADDR_CONTROL, {16'h0000, c | 16'h0001}, rs);
    j = 0;
    while (!result_load && j < 30000) begin
      @(posedge core_clk);
      j++;
    end
    `CHK(int'(($realtime - t_commit) / 5), n + 1)
    `CHK(busy, 1'h0)
    `CHK(result_data, e)
  endtask : conv

  task automatic note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : note

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    rst = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    ain_mode = 2'h0;
    ain_code = 10'h2A7;
    settle_after = 16'h0002;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    t0 = $realtime;
    rd(act_pkg::ADDR_STATUS, d, r);
    `CHK(d, 32'h00000002)
    rd(act_pkg::ADDR_CONTROL, d, r);
    `CHK(d, 32'h00000002)
    rd(act_pkg::ADDR_ALT_DIV, d, r);
    `CHK(d, 32'h00000003)
    rd(8'h10, d, r);
    `CHK({r, d}, {2'h2, 32'h00000000})
    wr(8'h10, 32'h00000001, r);
    `CHK(r, 2'h2)
    k = 0;
    while (fe_calibrate && k < 1000) begin
      @(posedge core_clk);
      k++;
    end
    `CHK((t_cal - t0) / 5 >= 16 && (t_cal - t0) / 5 <= 28, 1'h1)
    note("reset");
    // only divider 10 keeps the basic clock in range at 200 MHz
    for (i = 0; i < 4; i++) begin
      ctl = {i[1:0], i[1:0], 9'h000, i[1], ~i[0], 1'h0};
      conv(ctl, (st[i] + ct[i]) * rt[i] + 6,
           i[1] ? {ain_code[9:2], 2'h0} : ain_code);
    end
    note("timing");
    wr(act_pkg::ADDR_ALT_DIV, 32'h00000000, r);
    for (i = 1; i < 3; i++) begin
      ain_mode <= i[1:0];
      conv(16'h000A, 66, i == 1 ? 10'h000 : 10'h3FF);
    end
    ain_mode <= 2'h0;
    wr(act_pkg::ADDR_ALT_DIV, 32'h00000002, r);
    conv(16'h0008, 150, ain_code);
    rd(act_pkg::ADDR_STATUS, d, r);
    `CHK(d, 32'h00000004)
    rd(act_pkg::ADDR_RESULT, d, r);
    `CHK(d, {22'h000000, ain_code})
    rd(act_pkg::ADDR_STATUS, d, r);
    `CHK(d, 32'h00000000)
    note("clamp");
    rst <= 1'h1;
    settle_after <= 16'hFFFF;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    t0 = $realtime;
    conv(16'h0002, 246, ain_code);
    k = 0;
    while (fe_calibrate && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    `CHK((t_cal - t0) / 5 >= 314 && (t_cal - t0) / 5 <= 338, 1'h1)
    note("calibration");
    tally_and_finish();
  end
endmodule : adc_conversion_timing_bench
